// ==== rcs_pkg.sv ====
package rcs_pkg;

    // register addresses
    localparam logic [7:0] RCS_ADDR_LVL_LOW = 8'h00;
    localparam logic [7:0] RCS_ADDR_LVL_HIGH = 8'h01;
    localparam logic [7:0] RCS_ADDR_CTRL = 8'h02;
    localparam logic [7:0] RCS_ADDR_ID_VENDOR = 8'h03;
    localparam logic [7:0] RCS_ADDR_ID_REV = 8'h04;
    localparam logic [7:0] RCS_ADDR_MONITOR = 8'h05;

    // field positions
    localparam int RCS_LVL_SW_EN_BIT = 7;
    localparam int RCS_CTRL_DISCHARGE_BIT = 7;
    localparam int RCS_CTRL_SLEW_LSB = 4;
    localparam int RCS_CTRL_SOFT_RST_BIT = 2;
    localparam int RCS_CTRL_MODE_HIGH_BIT = 1;
    localparam int RCS_CTRL_MODE_LOW_BIT = 0;

    // reset values and writable control bits
    localparam logic RCS_LVL_SW_EN_RST = 1'b1;
    localparam logic [7:0] RCS_CTRL_RST = 8'h82;
    localparam logic [7:0] RCS_CTRL_RW_MASK = 8'hf3;

    // timing: one voltage-code step against the fastest ramp rate
    localparam longint RCS_CLK_PERIOD_PS = 40000;
    localparam longint RCS_CODE_STEP_UV = 6250;
    localparam longint RCS_FAST_SLEW_UV_PER_US = 64000;

    typedef struct packed {
        logic soft_start_done;
        logic input_low_lockout_flag;
        logic input_overvolt_flag;
        logic vout_at_setpoint;
        logic thermal_shutdown_flag;
    } rcs_analog_t;

    // cycles per code step at a ramp code, rounded up (rate is an upper bound)
    function automatic logic [9:0] rcs_step_cycles(input logic [2:0] code);
        longint num;
        longint den;
        num = RCS_CODE_STEP_UV * 64'd1000000 * (64'd1 << code);
        den = RCS_FAST_SLEW_UV_PER_US * RCS_CLK_PERIOD_PS;
        return 10'((num + den - 64'd1) / den);
    endfunction

endpackage

// ==== rcs_regs.sv ====
`timescale 1ns/1ps
module rcs_regs
    import rcs_pkg::*;
#(
    parameter logic [6:0] LVL_LOW_CODE_RST = 7'h50,
    parameter logic [6:0] LVL_HIGH_CODE_RST = 7'h50,
    // identity values are arbitrary
    parameter logic [2:0] VENDOR_CODE = 3'h2,
    parameter logic [3:0] DIE_CODE = 4'h3,
    parameter logic [3:0] DIE_REVISION = 4'h5
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register access port from the serial engine
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rd_valid,
    // pins and analog status
    input wire logic i_enable_pin,
    input wire logic i_level_select_pin,
    input wire rcs_analog_t i_analog,
    // controls to the power stage
    output logic o_regulator_on,
    output logic [6:0] o_voltage_code,
    output logic o_discharge_en,
    output logic [2:0] o_slew_code,
    output logic o_forced_pwm
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    logic en_pin_s;
    logic sel_pin_s;
    rcs_analog_t ana_s;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end else begin
            sync1_reg <= {i_enable_pin, i_level_select_pin, i_analog};
            sync2_reg <= sync1_reg;
        end
    end

    assign en_pin_s = sync2_reg[6];
    assign sel_pin_s = sync2_reg[5];
    assign ana_s = sync2_reg[4:0];

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] lvl_low_reg, lvl_low_next;
    logic [7:0] lvl_high_reg, lvl_high_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic reset_stat_reg, reset_stat_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rd_valid_reg, rd_valid_next;
    logic soft_rst;
    logic [7:0] lvl_sel;
    logic enabled;
    logic rising_reg, rising_next;
    logic falling_reg, falling_next;
    logic [7:0] monitor_val;

    assign soft_rst = i_wr_en && (i_addr == RCS_ADDR_CTRL) && i_wdata[RCS_CTRL_SOFT_RST_BIT];
    assign lvl_sel = sel_pin_s ? lvl_high_reg : lvl_low_reg;
    assign enabled = en_pin_s && lvl_sel[RCS_LVL_SW_EN_BIT];

    always_comb begin
        monitor_val = 8'h00;
        monitor_val[7] = enabled && ana_s.soft_start_done;
        monitor_val[6] = ana_s.input_low_lockout_flag;
        monitor_val[5] = ana_s.input_overvolt_flag;
        monitor_val[4] = rising_reg || (enabled && !ana_s.soft_start_done);
        monitor_val[3] = falling_reg;
        monitor_val[2] = reset_stat_reg;
        monitor_val[1] = ana_s.thermal_shutdown_flag;
        monitor_val[0] = enabled;
    end

    always_comb begin
        lvl_low_next = lvl_low_reg;
        lvl_high_next = lvl_high_reg;
        ctrl_next = ctrl_reg;
        reset_stat_next = reset_stat_reg;
        rd_valid_next = i_rd_en;
        rdata_next = rdata_reg;
        if (i_rd_en) begin
            case (i_addr)
                RCS_ADDR_LVL_LOW: rdata_next = lvl_low_reg;
                RCS_ADDR_LVL_HIGH: rdata_next = lvl_high_reg;
                RCS_ADDR_CTRL: rdata_next = ctrl_reg & RCS_CTRL_RW_MASK;
                RCS_ADDR_ID_VENDOR: rdata_next = {VENDOR_CODE, 1'b0, DIE_CODE};
                RCS_ADDR_ID_REV: rdata_next = {4'h0, DIE_REVISION};
                RCS_ADDR_MONITOR: begin
                    rdata_next = monitor_val;
                    reset_stat_next = 1'b0;
                end
                default: rdata_next = 8'h00;
            endcase
        end
        if (soft_rst) begin
            lvl_low_next = {RCS_LVL_SW_EN_RST, LVL_LOW_CODE_RST};
            lvl_high_next = {RCS_LVL_SW_EN_RST, LVL_HIGH_CODE_RST};
            ctrl_next = RCS_CTRL_RST;
            reset_stat_next = 1'b1;
        end else if (i_wr_en) begin
            // identity and monitor addresses fall to default and are ignored
            case (i_addr)
                RCS_ADDR_LVL_LOW: lvl_low_next = i_wdata;
                RCS_ADDR_LVL_HIGH: lvl_high_next = i_wdata;
                RCS_ADDR_CTRL: ctrl_next = i_wdata & RCS_CTRL_RW_MASK;
                default: ctrl_next = ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            lvl_low_reg <= {RCS_LVL_SW_EN_RST, LVL_LOW_CODE_RST};
            lvl_high_reg <= {RCS_LVL_SW_EN_RST, LVL_HIGH_CODE_RST};
            ctrl_reg <= RCS_CTRL_RST;
            reset_stat_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            lvl_low_reg <= lvl_low_next;
            lvl_high_reg <= lvl_high_next;
            ctrl_reg <= ctrl_next;
            reset_stat_reg <= reset_stat_next;
            rdata_reg <= rdata_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_rd_valid = rd_valid_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // setpoint ramp and power-stage controls

    logic [6:0] code_reg, code_next;
    logic [9:0] ramp_cnt_reg, ramp_cnt_next;
    logic on_reg, on_next;
    logic dis_reg, dis_next;
    logic [2:0] slew_reg, slew_next;
    logic fpwm_reg, fpwm_next;
    logic [6:0] target;

    assign target = lvl_sel[6:0];

    always_comb begin
        code_next = code_reg;
        ramp_cnt_next = ramp_cnt_reg;
        rising_next = 1'b0;
        falling_next = falling_reg;
        if (ana_s.vout_at_setpoint) begin
            falling_next = 1'b0;
        end
        if (!enabled) begin
            // a disabled stage restarts from the target through soft-start
            code_next = target;
            ramp_cnt_next = rcs_step_cycles(ctrl_reg[6:4]);
        end else if (target > code_reg) begin
            rising_next = 1'b1;
            if (ramp_cnt_reg <= 10'd1) begin
                code_next = code_reg + 7'h01;
                ramp_cnt_next = rcs_step_cycles(ctrl_reg[6:4]);
            end else begin
                ramp_cnt_next = ramp_cnt_reg - 10'd1;
            end
        end else if (target < code_reg) begin
            // falling steps are not slew limited; load discharges output
            code_next = target;
            falling_next = 1'b1;
            ramp_cnt_next = rcs_step_cycles(ctrl_reg[6:4]);
        end else begin
            ramp_cnt_next = rcs_step_cycles(ctrl_reg[6:4]);
        end
        on_next = enabled;
        dis_next = ctrl_reg[RCS_CTRL_DISCHARGE_BIT] && !enabled;
        slew_next = ctrl_reg[6:4];
        fpwm_next = sel_pin_s ? ctrl_reg[RCS_CTRL_MODE_HIGH_BIT]
                              : ctrl_reg[RCS_CTRL_MODE_LOW_BIT];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            code_reg <= LVL_LOW_CODE_RST;
            ramp_cnt_reg <= 10'd1;
            rising_reg <= 1'b0;
            falling_reg <= 1'b0;
            on_reg <= 1'b0;
            dis_reg <= 1'b0;
            slew_reg <= 3'h0;
            fpwm_reg <= 1'b0;
        end else begin
            code_reg <= code_next;
            ramp_cnt_reg <= ramp_cnt_next;
            rising_reg <= rising_next;
            falling_reg <= falling_next;
            on_reg <= on_next;
            dis_reg <= dis_next;
            slew_reg <= slew_next;
            fpwm_reg <= fpwm_next;
        end
    end

    assign o_regulator_on = on_reg;
    assign o_voltage_code = code_reg;
    assign o_discharge_en = dis_reg;
    assign o_slew_code = slew_reg;
    assign o_forced_pwm = fpwm_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_enable_gating: assert property (
        !en_pin_s |=> !o_regulator_on)
        else $error("regulator on while enable pin low");

    a_soft_reset_values: assert property (
        soft_rst |=> ctrl_reg == RCS_CTRL_RST && reset_stat_reg
            && lvl_low_reg == {RCS_LVL_SW_EN_RST, LVL_LOW_CODE_RST})
        else $error("soft reset did not restore defaults");

    a_ctrl_reserved_zero: assert property (
        i_rd_en && i_addr == RCS_ADDR_CTRL |=> o_rd_valid && o_rdata[3:2] == 2'b00)
        else $error("reserved or reset control bit read as one");

    a_status_clear_read: assert property (
        i_rd_en && i_addr == RCS_ADDR_MONITOR && !soft_rst |=> !reset_stat_reg)
        else $error("reset status not cleared by monitor read");

    a_ro_write_ignored: assert property (
        i_wr_en && i_addr >= RCS_ADDR_ID_VENDOR |=> $stable(ctrl_reg)
            && $stable(lvl_low_reg) && $stable(lvl_high_reg))
        else $error("write to read-only address changed state");

    a_mode_select: assert property (
        ##1 o_forced_pwm == ($past(sel_pin_s) ? $past(ctrl_reg[1]) : $past(ctrl_reg[0])))
        else $error("operating mode does not follow select pin");

    a_discharge_when_off: assert property (
        o_discharge_en |-> $past(ctrl_reg[RCS_CTRL_DISCHARGE_BIT]) && !o_regulator_on)
        else $error("pulldown active while enabled or not requested");

    a_ramp_single_step: assert property (
        o_regulator_on && $past(o_regulator_on) && o_voltage_code > $past(o_voltage_code)
            |-> o_voltage_code == $past(o_voltage_code) + 7'h01)
        else $error("rising ramp jumped more than one code");

    // at the fastest code the counter reloads to three, so any three ramp cycles with it at most three hold a step
    a_fast_ramp_rate: assert property (
        (enabled && ctrl_reg[6:4] == 3'h0 && target > code_reg
            && ramp_cnt_reg <= 10'd3) [*3] |=> code_reg != $past(code_reg, 3))
        else $error("fastest ramp missed a step");

    a_rising_flag: assert property (
        enabled && target > code_reg |=> rising_reg)
        else $error("rising flag missing during ramp");

    a_falling_step: assert property (
        enabled && target < code_reg |=> falling_reg && code_reg == $past(target))
        else $error("falling step not taken or flag missing");

    a_monitor_enable: assert property (
        i_rd_en && i_addr == RCS_ADDR_MONITOR |=> o_rdata[7] == $past(enabled && ana_s.soft_start_done)
            && o_rdata[0] == $past(enabled))
        else $error("monitor enable bits wrong");

    a_ident_reserved: assert property (
        i_rd_en && i_addr == RCS_ADDR_ID_VENDOR |=> o_rdata[4] == 1'b0)
        else $error("identity reserved bit read as one");

    a_code_follows_sel: assert property (
        !enabled |=> o_voltage_code == $past(target))
        else $error("disabled code does not follow selected level");

    a_slew_output: assert property (
        ##1 o_slew_code == $past(ctrl_reg[6:4]))
        else $error("ramp code output does not follow control");

    c_soft_reset: cover property (soft_rst);
    c_ramp_up: cover property (rising_reg ##1 !rising_reg);
    c_monitor_read: cover property (reset_stat_reg ##1 i_rd_en && i_addr == RCS_ADDR_MONITOR);
    c_fall_step: cover property (!falling_reg ##1 falling_reg);
    c_pulldown_on: cover property (o_discharge_en);

endmodule

// ==== rcs_host_model.sv ====
`timescale 1ns/1ps
module rcs_host_model (
    // clock
    input wire logic i_clk_sys,
    // strobe port toward the register bank
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    // random idle gap models a slow or prompt host; released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat ($urandom_range(1)) @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk_sys);
        o_wr_en <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    // register address is driven on the same clock edge as the read strobe
    task automatic rd(input logic [7:0] a);
        repeat ($urandom_range(1)) @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        o_rd_en <= 1'b1;
        o_addr <= a;
        @(posedge i_clk_sys);
        o_rd_en <= 1'b0;
        o_addr <= ~a;
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: %h not %h", $time, g, e); end end
module testbench;
    import rcs_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr_en, i_rd_en, o_rd_valid, o_regulator_on, o_discharge_en, o_forced_pwm;
    logic [7:0] i_addr, i_wdata, o_rdata, v, e_v;
    logic i_enable_pin = 1'b0;
    logic i_level_select_pin = 1'b0;
    rcs_analog_t i_analog = '0;
    logic [6:0] o_voltage_code;
    logic [6:0] lvl [2];
    logic [2:0] o_slew_code;
    logic [7:0] exp_q [$];
    int fails = 0;
    int comparisons = 0;
    int ticks = 0;
    int t0, n;
    int step_n [2] = '{3, 10};

    rcs_host_model rcs_host_model_i (.i_clk_sys(i_clk_sys), .o_wr_en(i_wr_en),
        .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));
    rcs_regs rcs_regs_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_rd_valid(o_rd_valid), .i_enable_pin(i_enable_pin),
        .i_level_select_pin(i_level_select_pin), .i_analog(i_analog),
        .o_regulator_on(o_regulator_on), .o_voltage_code(o_voltage_code),
        .o_discharge_en(o_discharge_en), .o_slew_code(o_slew_code),
        .o_forced_pwm(o_forced_pwm));

    initial begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    always @(posedge i_clk_sys) ticks <= ticks + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        rcs_host_model_i.rd(a);
    endtask

    task automatic pins(input logic en, input logic sel, input rcs_analog_t an);
        @(posedge i_clk_sys);
        i_enable_pin <= en;
        i_level_select_pin <= sel;
        i_analog <= an;
        cyc(5);
        @(negedge i_clk_sys);
    endtask

    task automatic end_sim;
        cyc(3);
        if (exp_q.size() != 0) fails++;
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // read answers are matched against the oldest noted expectation
    always @(negedge i_clk_sys) begin
        if (o_rd_valid === 1'b1) begin
            e_v = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
            `CHK(o_rdata, e_v)
        end
    end

    initial begin
        cyc(20000);
        fails++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(46));
        cyc(4);
        i_rst <= 1'b0;
        rd(8'h00, 8'hd0);
        rd(8'h01, 8'hd0);
        rd(8'h02, 8'h82);
        rd(8'h03, {3'h2, 1'b0, 4'h3});
        rd(8'h04, 8'h05);
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            lvl[i % 2] = v[6:0];
            rcs_host_model_i.wr(8'(i % 2), v);
            rd(8'(i % 2), v);
        end
        for (int a = 3; a < 6; a++) rcs_host_model_i.wr(8'(a), 8'hff);
        rd(8'h03, {3'h2, 1'b0, 4'h3});
        rd(8'h04, 8'h05);
        rd(8'h05, 8'h00);
        for (int c = 0; c < 8; c++) begin
            v = {~c[0], c[2:0], 2'b00, c[1:0]};
            rcs_host_model_i.wr(8'h02, v | 8'h08);
            rd(8'h02, v);
            pins(1'b0, c[2], 5'h00);
            `CHK(o_slew_code, c[2:0])
            `CHK(o_forced_pwm, c[2] ? c[1] : c[0])
            `CHK(o_discharge_en, v[7])
            `CHK(o_voltage_code, lvl[c[2]])
        end
        rcs_host_model_i.wr(8'h02, 8'h04);
        rd(8'h00, 8'hd0);
        rd(8'h01, 8'hd0);
        rd(8'h02, 8'h82);
        rd(8'h05, 8'h04);
        rd(8'h05, 8'h00);
        pins(1'b1, 1'b0, 5'h00);
        `CHK(o_regulator_on, 1'b1)
        `CHK(o_discharge_en, 1'b0)
        rd(8'h05, 8'h11);
        pins(1'b1, 1'b0, 5'h10);
        rd(8'h05, 8'h81);
        pins(1'b1, 1'b0, 5'h1d);
        rd(8'h05, 8'he3);
        pins(1'b1, 1'b0, 5'h10);
        for (int s = 0; s < 2; s++) begin
            rcs_host_model_i.wr(8'h02, s ? 8'ha2 : 8'h82);
            rcs_host_model_i.wr(8'h00, 8'hd4 + 8'(4 * s));
            t0 = ticks;
            rd(8'h05, 8'h91);
            n = 0;
            while (o_voltage_code !== 7'h54 + 7'(4 * s) && n < 200) begin
                @(negedge i_clk_sys);
                n++;
            end
            if (n >= 200) fails++;
            n = ticks - t0;
            `CHK(n >= 4 * step_n[s] - 3 && n <= 4 * step_n[s] + 2, 1'b1)
            rd(8'h05, 8'h81);
        end
        rcs_host_model_i.wr(8'h00, 8'hc0);
        cyc(2);
        @(negedge i_clk_sys);
        `CHK(o_voltage_code, 7'h40)
        rd(8'h05, 8'h89);
        pins(1'b1, 1'b0, 5'h12);
        rd(8'h05, 8'h81);
        rcs_host_model_i.wr(8'h00, 8'h40);
        rd(8'h05, 8'h00);
        @(negedge i_clk_sys);
        `CHK(o_regulator_on, 1'b0)
        `CHK(o_discharge_en, 1'b1)
        end_sim();
    end
endmodule
